/* File: design/gfm_pkg.sv */
// Shared constants, types and helpers for the manual test and reset sequencer
package gfm_pkg;

  // ****************************************************************
  // Clock and time base
  // ****************************************************************
  localparam int unsigned CLK_HZ                  = 25_000_000;
  localparam int unsigned MS_PER_S                = 1000;
  localparam int unsigned CYC_PER_MS              = CLK_HZ / MS_PER_S;

  // ****************************************************************
  // Times in milliseconds
  // ****************************************************************
  localparam int unsigned TEST_DEBOUNCE_MS        = 20;
  localparam int unsigned SWITCH_DEBOUNCE_TIME_MS = 100;
  localparam int unsigned SW_RESET_MIN_MS         = 55;
  localparam int unsigned SW_RESET_MAX_MS         = 75;
  localparam int unsigned BLINK_HALF_MS           = 1000;
  localparam int unsigned TRIP_PULSE_MS           = 2;

  // ****************************************************************
  // Widths and constant values
  // ****************************************************************
  localparam int          CNT_W                   = 32;
  localparam int          FAULT_W                 = 3;
  localparam logic [FAULT_W-1:0] FAULT_ZERO       = 3'h0;
  localparam logic [FAULT_W-1:0] FAULT_ONE        = 3'h1;
  localparam logic [FAULT_W-1:0] FAULT_LIMIT      = 3'h5;
  localparam logic [CNT_W-1:0]   CNT_ZERO         = 32'h0;
  localparam logic [CNT_W-1:0]   CNT_ONE          = 32'h1;
  localparam logic [CNT_W-1:0]   CNT_MAX          = 32'hFFFFFFFF;
  localparam logic               LEVEL_IDLE       = 1'h1;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [1:0] {
    GFM_MT_IDLE,
    GFM_MT_WAIT,
    GFM_MT_HOLD
  } gfm_mt_state_t;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  // Milliseconds to clock cycles, never less than one cycle
  function automatic int unsigned gfm_ms_to_cyc(input int unsigned ms);
    int unsigned cyc;
    cyc = ms * CYC_PER_MS;
    return (cyc == 0) ? 1 : cyc;
  endfunction

endpackage

/* File: design/gfm_debounce.sv */
// Debouncer: output level follows the input once it has stayed put long enough
`timescale 1ns/1ps
module gfm_debounce #(
  parameter int unsigned STABLE_CYC = 1
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic clk_en,
  input  wire logic raw_in,
  output logic      level_out,
  output logic      fell_out,
  output logic      rose_out
);

  typedef struct packed {
    logic                       level;
    logic                       fell;
    logic                       rose;
    logic [gfm_pkg::CNT_W-1:0]  cnt;
  } gfm_deb_state_t;

  gfm_deb_state_t st_reg;
  gfm_deb_state_t st_next;

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    st_next      = st_reg;
    st_next.fell = 1'b0;
    st_next.rose = 1'b0;
    if (raw_in == st_reg.level) begin
      st_next.cnt = gfm_pkg::CNT_ZERO;
    end else if (st_reg.cnt == gfm_pkg::CNT_W'(STABLE_CYC - 1)) begin
      st_next.cnt   = gfm_pkg::CNT_ZERO;
      st_next.level = raw_in;
      st_next.fell  = !raw_in;
      st_next.rose  = raw_in;
    end else begin
      st_next.cnt = st_reg.cnt + gfm_pkg::CNT_ONE;
    end
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '{level: gfm_pkg::LEVEL_IDLE, fell: 1'b0, rose: 1'b0, cnt: gfm_pkg::CNT_ZERO};
    end else if (clk_en) begin
      st_reg <= st_next;
    end
  end

  assign level_out = st_reg.level;
  assign fell_out  = st_reg.fell;
  assign rose_out  = st_reg.rose;

endmodule

/* File: design/gfm_manual_test_reset_seq.sv */
// Manual self-test and switch-open reset sequencer of a ground-fault interrupter
`timescale 1ns/1ps
module gfm_manual_test_reset_seq #(
  parameter int unsigned TEST_DEBOUNCE_CYC         =
    gfm_pkg::gfm_ms_to_cyc(gfm_pkg::TEST_DEBOUNCE_MS),
  parameter int unsigned SWITCH_DEBOUNCE_TIME_CYC  =
    gfm_pkg::gfm_ms_to_cyc(gfm_pkg::SWITCH_DEBOUNCE_TIME_MS),
  parameter int unsigned SW_RESET_MIN_CYC          =
    gfm_pkg::gfm_ms_to_cyc(gfm_pkg::SW_RESET_MIN_MS),
  parameter int unsigned SW_RESET_MAX_CYC          =
    gfm_pkg::gfm_ms_to_cyc(gfm_pkg::SW_RESET_MAX_MS),
  parameter int unsigned BLINK_HALF_CYC            =
    gfm_pkg::gfm_ms_to_cyc(gfm_pkg::BLINK_HALF_MS),
  parameter int unsigned TRIP_PULSE_CYC            =
    gfm_pkg::gfm_ms_to_cyc(gfm_pkg::TRIP_PULSE_MS)
) (
  input  wire logic                        clk,
  input  wire logic                        rst_n,
  input  wire logic                        clk_en,
  input  wire logic                        manual_test_button_n,
  input  wire logic                        switch_open_n,
  input  wire logic                        self_test_done,
  input  wire logic                        self_test_pass,
  input  wire logic                        periodic_test_fail,
  input  wire logic                        periodic_test_pass,
  output logic                             self_test_req,
  output logic                             trip_drive,
  output logic                             alarm_out,
  output logic                             device_reset,
  output logic [gfm_pkg::FAULT_W-1:0]      fault_count
);

  typedef struct packed {
    gfm_pkg::gfm_mt_state_t           mt_state;
    logic                             req;
    logic [gfm_pkg::FAULT_W-1:0]      fault_count;
    logic                             blink;
    logic                             blink_on;
    logic [gfm_pkg::CNT_W-1:0]        blink_cnt;
    logic                             steady;
    logic                             trip;
    logic [gfm_pkg::CNT_W-1:0]        trip_cnt;
    logic [gfm_pkg::CNT_W-1:0]        sw_low_cnt;
    logic                             sw_raw_prev;
    logic                             soft_reset;
    logic                             alarm;
  } gfm_seq_state_t;

  gfm_seq_state_t st_reg;
  gfm_seq_state_t st_next;

  logic test_level;
  logic test_fell;
  logic sw_level;
  logic sw_fell;
  logic sw_rose;
  logic mt_pass;
  logic mt_fail;

  // ****************************************************************
  // Input debouncers
  // ****************************************************************
  gfm_debounce #(
    .STABLE_CYC (TEST_DEBOUNCE_CYC)
  ) u_test_deb (
    .clk       (clk),
    .rst_n     (rst_n),
    .clk_en    (clk_en),
    .raw_in    (manual_test_button_n),
    .level_out (test_level),
    .fell_out  (test_fell),
    .rose_out  ()
  );

  gfm_debounce #(
    .STABLE_CYC (SWITCH_DEBOUNCE_TIME_CYC)
  ) u_sw_deb (
    .clk       (clk),
    .rst_n     (rst_n),
    .clk_en    (clk_en),
    .raw_in    (switch_open_n),
    .level_out (sw_level),
    .fell_out  (sw_fell),
    .rose_out  (sw_rose)
  );

  assign mt_pass = (st_reg.mt_state == gfm_pkg::GFM_MT_WAIT) && self_test_done && self_test_pass;
  assign mt_fail = (st_reg.mt_state == gfm_pkg::GFM_MT_WAIT) && self_test_done && !self_test_pass;

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    logic                        fire;
    logic                        clr_cnt;
    logic                        set_blink;
    logic                        clr_blink;
    logic [gfm_pkg::FAULT_W-1:0] cnt_base;
    fire       = 1'b0;
    clr_cnt    = 1'b0;
    set_blink  = 1'b0;
    clr_blink  = 1'b0;
    cnt_base   = gfm_pkg::FAULT_ZERO;
    st_next    = st_reg;
    st_next.req        = 1'b0;
    st_next.soft_reset = 1'b0;

    // Manual test sequence
    unique case (st_reg.mt_state)
      gfm_pkg::GFM_MT_IDLE: begin
        if (test_fell) begin
          st_next.req      = 1'b1;
          st_next.mt_state = gfm_pkg::GFM_MT_WAIT;
        end
      end
      gfm_pkg::GFM_MT_WAIT: begin
        if (self_test_done) begin
          if (self_test_pass) begin
            fire      = 1'b1;
            clr_cnt   = 1'b1;
            clr_blink = 1'b1;
          end else begin
            set_blink = 1'b1;
          end
          st_next.mt_state = gfm_pkg::GFM_MT_HOLD;
        end
      end
      gfm_pkg::GFM_MT_HOLD: begin
        if (test_level) begin
          st_next.mt_state = gfm_pkg::GFM_MT_IDLE;
        end
      end
    endcase

    // Switch-open debounced edges
    if (sw_fell) begin
      fire           = 1'b1;
      clr_cnt        = 1'b1;
      st_next.steady = 1'b1;
    end
    if (sw_rose) begin
      st_next.steady = 1'b0;
    end

    // Short switch-open pulse resets without firing
    st_next.sw_raw_prev = switch_open_n;
    if (!switch_open_n) begin
      if (st_reg.sw_low_cnt != gfm_pkg::CNT_MAX) begin
        st_next.sw_low_cnt = st_reg.sw_low_cnt + gfm_pkg::CNT_ONE;
      end
    end else begin
      st_next.sw_low_cnt = gfm_pkg::CNT_ZERO;
      if (!st_reg.sw_raw_prev && sw_level &&
          st_reg.sw_low_cnt >= gfm_pkg::CNT_W'(SW_RESET_MIN_CYC) &&
          st_reg.sw_low_cnt <= gfm_pkg::CNT_W'(SW_RESET_MAX_CYC)) begin
        st_next.soft_reset = 1'b1;
        clr_cnt            = 1'b1;
        st_next.mt_state   = gfm_pkg::GFM_MT_IDLE;
      end
    end

    // Consecutive periodic failure counter, a new failure wins over a clear
    cnt_base = clr_cnt ? gfm_pkg::FAULT_ZERO : st_reg.fault_count;
    if (periodic_test_pass) begin
      cnt_base = gfm_pkg::FAULT_ZERO;
    end
    if (periodic_test_fail && cnt_base != gfm_pkg::FAULT_LIMIT) begin
      cnt_base = cnt_base + gfm_pkg::FAULT_ONE;
      if (cnt_base == gfm_pkg::FAULT_LIMIT) begin
        fire      = 1'b1;
        set_blink = 1'b1;
      end
    end
    st_next.fault_count = cnt_base;

    // Blink latch and one second phases, set wins over clear
    if (set_blink && !st_reg.blink) begin
      st_next.blink     = 1'b1;
      st_next.blink_on  = 1'b1;
      st_next.blink_cnt = gfm_pkg::CNT_ZERO;
    end else if (clr_blink && !set_blink) begin
      st_next.blink = 1'b0;
    end else if (st_reg.blink) begin
      if (st_reg.blink_cnt == gfm_pkg::CNT_W'(BLINK_HALF_CYC - 1)) begin
        st_next.blink_cnt = gfm_pkg::CNT_ZERO;
        st_next.blink_on  = !st_reg.blink_on;
      end else begin
        st_next.blink_cnt = st_reg.blink_cnt + gfm_pkg::CNT_ONE;
      end
    end

    // Trip pulse
    if (fire) begin
      st_next.trip     = 1'b1;
      st_next.trip_cnt = gfm_pkg::CNT_ZERO;
    end else if (st_reg.trip) begin
      if (st_reg.trip_cnt == gfm_pkg::CNT_W'(TRIP_PULSE_CYC - 1)) begin
        st_next.trip = 1'b0;
      end else begin
        st_next.trip_cnt = st_reg.trip_cnt + gfm_pkg::CNT_ONE;
      end
    end

    // Blinking overrides the steady switch-open alarm
    st_next.alarm = st_next.blink ? st_next.blink_on : st_next.steady;
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '{mt_state:    gfm_pkg::GFM_MT_IDLE,
                  req:         1'b0,
                  fault_count: gfm_pkg::FAULT_ZERO,
                  blink:       1'b0,
                  blink_on:    1'b0,
                  blink_cnt:   gfm_pkg::CNT_ZERO,
                  steady:      1'b0,
                  trip:        1'b0,
                  trip_cnt:    gfm_pkg::CNT_ZERO,
                  sw_low_cnt:  gfm_pkg::CNT_ZERO,
                  sw_raw_prev: gfm_pkg::LEVEL_IDLE,
                  soft_reset:  1'b0,
                  alarm:       1'b0};
    end else if (clk_en) begin
      st_reg <= st_next;
    end
  end

  assign self_test_req = st_reg.req;
  assign trip_drive    = st_reg.trip;
  assign alarm_out     = st_reg.alarm;
  assign device_reset  = st_reg.soft_reset;
  assign fault_count   = st_reg.fault_count;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  chk_req_after_fall: assert property (
    clk_en && test_fell && st_reg.mt_state == gfm_pkg::GFM_MT_IDLE |=> self_test_req)
    else $error("self-test request missing after debounced button fall");

  chk_req_cause: assert property (
    self_test_req |-> $past(test_fell) && !test_level)
    else $error("self-test request without debounced button fall");

  chk_pass_effects: assert property (
    clk_en && mt_pass && !periodic_test_fail |=> trip_drive && fault_count == 3'h0 && !st_reg.blink)
    else $error("passing manual test did not fire, clear and stop blinking");

  chk_fail_no_trip: assert property (
    clk_en && mt_fail && !trip_drive && !sw_fell && !periodic_test_fail && !periodic_test_pass
    && !st_next.soft_reset |=> !trip_drive && st_reg.blink && $stable(fault_count))
    else $error("failing manual test changed trip or counter, or no blink");

  chk_switch_fire: assert property (
    clk_en && sw_fell && !periodic_test_fail |=> trip_drive && fault_count == 3'h0 && st_reg.steady)
    else $error("switch-open fall did not fire, clear and light alarm");

  chk_switch_off: assert property (
    clk_en && sw_rose |=> !st_reg.steady)
    else $error("steady alarm not cleared after switch-open rise");

  chk_short_reset: assert property (
    device_reset |-> sw_level && $past(sw_level))
    else $error("short switch-open reset while the switch had fired");

  chk_blink_keep: assert property (
    clk_en && st_reg.blink && !mt_pass |=> st_reg.blink)
    else $error("blinking stopped without a passing manual test");

  chk_five_fails: assert property (
    clk_en && fault_count == 3'h4 && periodic_test_fail && !periodic_test_pass && !sw_fell
    && !mt_pass && !st_next.soft_reset |=> trip_drive && st_reg.blink && fault_count == 3'h5)
    else $error("fifth consecutive failure did not trip and blink");

  chk_blink_alarm: assert property (
    clk_en && st_next.blink |=> alarm_out == st_reg.blink_on)
    else $error("alarm does not follow blink phase");

  chk_hold_release: assert property (
    st_reg.mt_state == gfm_pkg::GFM_MT_HOLD && !test_level && !st_next.soft_reset
    |=> st_reg.mt_state != gfm_pkg::GFM_MT_IDLE)
    else $error("manual test ended while button still held");

  cov_mt_pass: cover property (mt_pass ##1 trip_drive);
  cov_mt_fail: cover property (mt_fail ##1 st_reg.blink);
  cov_short_reset: cover property (device_reset);
  cov_five_fails: cover property (fault_count == 3'h5 && st_reg.blink);

endmodule

/* File: dv/gfm_partner.sv */
// Far-side model: test button, switch assembly and analog self-test answer
`timescale 1ns/1ps
module gfm_partner (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        btn_go,
  input  wire logic [15:0] btn_len,
  input  wire logic        sw_go,
  input  wire logic [15:0] sw_len,
  input  wire logic        st_pass,
  input  wire logic [3:0]  st_delay,
  input  wire logic        self_test_req,
  output logic             manual_test_button_n,
  output logic             switch_open_n,
  output logic             self_test_done,
  output logic             self_test_pass
);
  logic [15:0] btn_cnt;
  logic [15:0] sw_cnt;
  logic [3:0]  st_cnt;
  // ****************************************************************
  // Press, hold and release
  // ****************************************************************
  assign manual_test_button_n = (btn_cnt == 16'h0);
  assign switch_open_n        = (sw_cnt == 16'h0);
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      btn_cnt        <= 16'h0;
      sw_cnt         <= 16'h0;
      st_cnt         <= 4'h0;
      self_test_done <= 1'b0;
      self_test_pass <= 1'b0;
    end else begin
      if (btn_go) btn_cnt <= btn_len;
      else if (btn_cnt != 16'h0) btn_cnt <= btn_cnt - 16'h1;
      if (sw_go) sw_cnt <= sw_len;
      else if (sw_cnt != 16'h0) sw_cnt <= sw_cnt - 16'h1;
      // Self-test answer after a chosen delay; result line toggles when idle
      if (self_test_req) st_cnt <= st_delay;
      else if (st_cnt != 4'h0) st_cnt <= st_cnt - 4'h1;
      self_test_done <= (st_cnt == 4'h1);
      self_test_pass <= (st_cnt == 4'h1) ? st_pass : ~self_test_pass;
    end
  end
endmodule

/* File: dv/gfci_manual_test_reset_seq_test.sv */
// Self-checking testbench of the manual test and reset sequencer
`timescale 1ns/1ps
`define CHK(a, b) check_eq((a), (b))
module gfci_manual_test_reset_seq_test;
  localparam int TDB = 8;
  localparam int SDB = 40;
  localparam int BH  = 16;
  localparam int TP  = 4;
  localparam int LIMIT = 20000;
  logic clk = 1'b0, rst_n = 1'b0, clk_en = 1'b1, p_fail = 1'b0, p_pass = 1'b0;
  logic btn_go = 1'b0, sw_go = 1'b0, st_pass = 1'b0;
  logic [15:0] btn_len = 16'h0, sw_len = 16'h0;
  logic [3:0]  st_delay = 4'h1;
  logic button_n, switch_n, st_done, st_res, st_req, trip, alarm, dev_rst, al_q = 1'b0;
  logic [gfm_pkg::FAULT_W-1:0] fcnt;
  int seed = 32'h418c;
  int n_mismatch = 0, n_checks = 0, cyc = 0;
  int n_trip = 0, n_req = 0, n_rst = 0, n_alarm = 0, run = 0, on_run = 0, off_run = 0;
  int b_trip, b_req, b_rst, b_al, k;
  // ****************************************************************
  // Design, far side and clock
  // ****************************************************************
  gfm_manual_test_reset_seq #(
    .TEST_DEBOUNCE_CYC(TDB), .SWITCH_DEBOUNCE_TIME_CYC(SDB), .SW_RESET_MIN_CYC(10),
    .SW_RESET_MAX_CYC(20), .BLINK_HALF_CYC(BH), .TRIP_PULSE_CYC(TP)
  ) DUT (
    .clk(clk), .rst_n(rst_n), .clk_en(clk_en), .manual_test_button_n(button_n),
    .switch_open_n(switch_n), .self_test_done(st_done), .self_test_pass(st_res),
    .periodic_test_fail(p_fail), .periodic_test_pass(p_pass), .self_test_req(st_req),
    .trip_drive(trip), .alarm_out(alarm), .device_reset(dev_rst), .fault_count(fcnt)
  );
  gfm_partner far_side (
    .clk(clk), .rst_n(rst_n), .btn_go(btn_go), .btn_len(btn_len), .sw_go(sw_go),
    .sw_len(sw_len), .st_pass(st_pass), .st_delay(st_delay), .self_test_req(st_req),
    .manual_test_button_n(button_n), .switch_open_n(switch_n),
    .self_test_done(st_done), .self_test_pass(st_res)
  );
  always #20 clk = ~clk;
  // ****************************************************************
  // Output monitor and timeout
  // ****************************************************************
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (trip === 1'b1) n_trip <= n_trip + 1;
    if (st_req === 1'b1) n_req <= n_req + 1;
    if (dev_rst === 1'b1) n_rst <= n_rst + 1;
    if (alarm === 1'b1) n_alarm <= n_alarm + 1;
    if (alarm !== al_q) begin
      if (al_q) on_run <= run;
      else off_run <= run;
      run <= 1;
    end else run <= run + 1;
    al_q <= alarm;
    if (cyc == LIMIT) begin
      n_mismatch = n_mismatch + 1;
      $display("ERROR at %0t: run did not finish in time", $time);
      print_verdict();
    end
  end
  // ****************************************************************
  // Tasks and expectations
  // ****************************************************************
  function automatic int exp_trip(input int fires);
    return fires * TP;
  endfunction
  task automatic check_eq(input logic [31:0] got, input logic [31:0] exp);
    n_checks = n_checks + 1;
    if (got !== exp) begin
      n_mismatch = n_mismatch + 1;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic snap();
    b_trip = n_trip; b_req = n_req; b_rst = n_rst; b_al = n_alarm;
  endtask
  task automatic press(input int len, input logic pass);
    @(posedge clk);
    btn_len <= len[15:0]; btn_go <= 1'b1; st_pass <= pass;
    st_delay <= 4'(($random(seed) & 7) + 1);
    @(posedge clk) btn_go <= 1'b0;
    tick(len + 40);
  endtask
  task automatic sw(input int len);
    @(posedge clk);
    sw_len <= len[15:0]; sw_go <= 1'b1;
    @(posedge clk) sw_go <= 1'b0;
  endtask
  task automatic pfail(input int n);
    repeat (n) begin
      @(posedge clk) p_fail <= 1'b1;
      @(posedge clk) p_fail <= 1'b0;
    end
  endtask
  task automatic done_test(input string name);
    $display("test %s done, mismatches so far %0d", name, n_mismatch);
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    tick(20);
    `CHK({trip, alarm, st_req, dev_rst, fcnt}, 32'h0);
    rst_n <= 1'b1;
    tick(3);
    done_test("reset");
    k = ($random(seed) & 3) + 1;
    pfail(k);
    snap();
    press(4 + (($random(seed) & 1) * 3), 1'b1);
    `CHK(n_req - b_req, 32'h0);
    `CHK(fcnt, k);
    press(30 + ($random(seed) & 15), 1'b1);
    `CHK(n_req - b_req, 32'h1);
    `CHK(n_trip - b_trip, exp_trip(1));
    `CHK(fcnt, 32'h0);
    `CHK(n_alarm - b_al, 32'h0);
    done_test("manual pass");
    pfail(2);
    @(posedge clk) p_pass <= 1'b1;
    @(posedge clk) p_pass <= 1'b0;
    tick(2);
    `CHK(fcnt, 32'h0);
    k = ($random(seed) & 3) + 1;
    pfail(k);
    snap();
    press(30 + ($random(seed) & 15), 1'b0);
    tick(3 * BH);
    `CHK(n_req - b_req, 32'h1);
    `CHK(n_trip - b_trip, 32'h0);
    `CHK(fcnt, k);
    `CHK(on_run, BH);
    `CHK(off_run, BH);
    done_test("manual fail");
    snap();
    sw(SDB + 60);
    tick(SDB + 6);
    `CHK(n_trip - b_trip, exp_trip(1));
    `CHK(fcnt, 32'h0);
    snap();
    tick(2 * BH);
    `CHK(n_alarm - b_al, BH);
    tick(SDB + 40);
    done_test("switch while blinking");
    snap();
    press(30, 1'b1);
    snap();
    tick(3 * BH);
    `CHK(n_alarm - b_al, 32'h0);
    done_test("pass stops blink");
    pfail(3);
    snap();
    sw(SDB + 30);
    tick(SDB + 8);
    `CHK(alarm, 1'b1);
    `CHK(n_trip - b_trip, exp_trip(1));
    `CHK(fcnt, 32'h0);
    tick(SDB + 20);
    `CHK(alarm, 1'b1);
    tick(15);
    `CHK(alarm, 1'b0);
    done_test("switch steady");
    for (k = 0; k < 3; k++) begin
      pfail(2);
      snap();
      sw(k == 0 ? 11 : (k == 1 ? 19 : 12 + ($random(seed) & 7) % 7));
      tick(SDB + 10);
      `CHK(n_rst - b_rst, 32'h1);
      `CHK(n_trip - b_trip, 32'h0);
      `CHK(fcnt, 32'h0);
    end
    done_test("short reset");
    snap();
    pfail(5);
    tick(3 * BH);
    `CHK(fcnt, 32'h5);
    `CHK(n_trip - b_trip, exp_trip(1));
    `CHK(on_run, BH);
    // Clock enable low freezes the blink phase and the counter
    @(posedge clk) clk_en <= 1'b0;
    @(posedge clk) b_al = alarm;
    tick(BH);
    `CHK(alarm, b_al);
    `CHK(fcnt, 32'h5);
    clk_en <= 1'b1;
    @(posedge clk) rst_n <= 1'b0;
    tick(2);
    rst_n <= 1'b1;
    snap();
    tick(3 * BH);
    `CHK(n_alarm - b_al, 32'h0);
    done_test("five failures");
    print_verdict();
  end
endmodule
